//--- hw/ssd_setup_decode.sv
// Setup word decoder: Wishbone register, start-up sequencing and output path controls.
// Assumes nvm_word is stable from reset release and all inputs are synchronous to ref_clk.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
module ssd_setup_decode #(
    parameter bit DIGITAL_VARIANT = 1'b1,
    parameter int DIAG_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input ssd_pkg::ssd_wb_req_t wb_req,
    output ssd_pkg::ssd_wb_rsp_t wb_rsp,
    input wire logic [ssd_pkg::SETUP_W-1:0] nvm_word,
    input wire logic [DIAG_W-1:0] diag_raw,
    input wire logic ovv_raw,
    input wire logic short_raw,
    input wire logic sample_valid,
    input wire logic [ssd_pkg::SAMPLE_W-1:0] pos_val,
    input wire logic [ssd_pkg::SAMPLE_W-1:0] temp_val,
    input wire logic [ssd_pkg::SAMPLE_W-1:0] mag_val,
    output ssd_pkg::ssd_ctl_t ctl,
    output ssd_pkg::ssd_pin_t pin,
    output ssd_pkg::ssd_sent_t sent,
    output logic [DIAG_W-1:0] diag_flags
);
    import ssd_pkg::*;

    logic [SETUP_W-1:0] setup_r;
    logic armed_r;
    ssd_start_t state_r;
    logic ack_r;
    logic [31:0] rdat_r;
    ssd_ctl_t ctl_r;
    ssd_ctl_t ctl_nxt;
    ssd_pin_t pin_r;
    ssd_pin_t pin_nxt;
    ssd_sent_t sent_r;
    ssd_sent_t sent_nxt;
    logic [DIAG_W-1:0] diag_q;
    logic [1:0] short_mode;
    logic req;
    logic wr_hit;
    logic ovv_act;
    logic short_act;
    logic err_act;
    logic [31:0] status_w;

    // Bus request decode.
    assign req = wb_req.cyc & wb_req.stb;
    assign wr_hit = req & wb_req.we & ack_r & (wb_req.adr == ADDR_SETUP1);

    // Live conditions: overvoltage and errors gated by their setup bits, shorts by the armed flag.
    assign short_mode = setup_r[B_SHORT_LO +: 2];
    assign ovv_act = ovv_raw & ~setup_r[B_OVV_DIS];
    assign short_act = short_raw & armed_r;
    assign err_act = (|diag_q) & ~setup_r[B_DIAG_HIDE];

    // Classic Wishbone ack: one cycle after the request is seen, dropped the cycle after.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Status view of the block's own state.
    always_comb begin
        status_w = '0;
        status_w[ST_DIAG_LO +: DIAG_W] = diag_q;
        status_w[ST_OVV] = ovv_act;
        status_w[ST_SHORT] = short_act;
        status_w[ST_ARMED] = armed_r;
        status_w[ST_LOCKED] = setup_r[B_LOCK];
        status_w[ST_RUN] = (state_r == ST_RUNNING);
    end

    // Read data is captured with the ack; unmapped offsets read as zero.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdat_r <= '0;
        end else if (req & ~ack_r) begin
            unique case (wb_req.adr)
                ADDR_SETUP1: rdat_r <= {16'h0000, setup_r};
                ADDR_STATUS: rdat_r <= status_w;
                default: rdat_r <= '0;
            endcase
        end
    end

    assign wb_rsp.ack = ack_r;
    assign wb_rsp.dat = rdat_r;

    // Setup word: loaded from memory after reset, then written only while unlocked.
    // Reserved bits are stored as written but steer nothing.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_r <= '0;
        end else if (state_r == ST_LOAD) begin
            setup_r <= nvm_word;
        end else if (wr_hit && !setup_r[B_LOCK]) begin
            if (wb_req.sel[0]) begin
                setup_r[7:0] <= wb_req.dat[7:0];
            end
            if (wb_req.sel[1]) begin
                setup_r[15:8] <= wb_req.dat[15:8];
            end
        end
    end

    // Short detection arms only from a lock already stored before this reset.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_r <= 1'b0;
        end else if (state_r == ST_LOAD) begin
            armed_r <= nvm_word[B_LOCK];
        end
    end

    // Start-up sequence: load the word, then wait for the first valid sample.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_LOAD;
        end else begin
            unique case (state_r)
                ST_LOAD: state_r <= ST_WAIT_SAMPLE;
                ST_WAIT_SAMPLE: state_r <= sample_valid ? ST_RUNNING : ST_WAIT_SAMPLE;
                ST_RUNNING: state_r <= ST_RUNNING;
            endcase
        end
    end

    ssd_diag_latch #(
        .W(DIAG_W)
    ) u_diag (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .latch_en(setup_r[B_DIAG_LATCH]),
        .cond(diag_raw),
        .flags(diag_q)
    );

    assign diag_flags = diag_q;

    // Field decode into the output path controls.
    always_comb begin
        ctl_nxt.interp_en = setup_r[B_INTERP];
        ctl_nxt.interp_steps = setup_r[B_INTERP] ? INTERP_STEPS : INTERP_OFF;
        ctl_nxt.fc2_mag = setup_r[B_FC2_MAG];
        ctl_nxt.proto_sent = DIGITAL_VARIANT & setup_r[B_PROTO_SENT];
        ctl_nxt.burn_in = setup_r[B_BURN_IN];
        ctl_nxt.func_normal = setup_r[B_FUNC_NORMAL];
        ctl_nxt.ovv_det_en = ~setup_r[B_OVV_DIS];
        ctl_nxt.diag_latch = setup_r[B_DIAG_LATCH];
        ctl_nxt.diag_show = ~setup_r[B_DIAG_HIDE];
    end

    // Pin control; a short outranks overvoltage, which outranks the error band.
    // A stuck pair of sensors must release the line first, or both keep fighting.
    always_comb begin
        pin_nxt = '0;
        pin_nxt.drive_en = 1'b1;
        if (short_act) begin
            if (!DIGITAL_VARIANT && setup_r[B_LOCK] && short_mode == SHORT_RAIL) begin
                pin_nxt.force_high = 1'b1;
            end else if (!DIGITAL_VARIANT && setup_r[B_LOCK] && short_mode == SHORT_GND) begin
                pin_nxt.force_low = 1'b1;
            end else begin
                pin_nxt.drive_en = 1'b0;
            end
        end else if (DIGITAL_VARIANT && ovv_act) begin
            if (setup_r[B_ERR_BAND]) begin
                pin_nxt.force_low = 1'b1;
            end else if (!setup_r[B_PROTO_SENT]) begin
                pin_nxt.pwm_half_freq = 1'b1;
                pin_nxt.pwm_duty75 = 1'b1;
            end
        end else if (!DIGITAL_VARIANT && (err_act || ovv_act)) begin
            pin_nxt.force_high = ~setup_r[B_ERR_BAND];
            pin_nxt.force_low = setup_r[B_ERR_BAND];
        end
    end

    // SENT channel content, including start-up and overvoltage codes.
    always_comb begin
        sent_nxt.fc2 = setup_r[B_FC2_MAG] ? mag_val : temp_val;
        sent_nxt.status_err = err_act;
        if (state_r != ST_RUNNING) begin
            sent_nxt.fc1 = setup_r[B_SENT_ZERO] ? SENT_ZERO_CODE : SENT_START_CODE;
            if (setup_r[B_SENT_ZERO]) begin
                sent_nxt.fc2 = SENT_ZERO_CODE;
            end else begin
                sent_nxt.status_err = 1'b0;
            end
        end else if (ovv_act && !setup_r[B_ERR_BAND]) begin
            sent_nxt.fc1 = SENT_OVV_CODE;
        end else begin
            sent_nxt.fc1 = pos_val;
        end
    end

    // Control outputs; registered so the output stage never sees a decode glitch.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Pin controls land one cycle after their cause.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_r <= '0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // SENT channel words land one cycle after their cause.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sent_r <= '0;
        end else begin
            sent_r <= sent_nxt;
        end
    end

    assign ctl = ctl_r;
    assign pin = pin_r;
    assign sent = sent_r;

    // Checks and coverage.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_wb_ack_pulse: assert property (ack_r |=> !ack_r)
        else $error("ack stayed high for two cycles");

    a_lock_blocks_write: assert property (
        (state_r != ST_LOAD) && setup_r[B_LOCK] |=> $stable(setup_r))
        else $error("setup word changed while locked");

    a_short_tristate: assert property (
        short_act && (short_mode == SHORT_TRI_A || short_mode == SHORT_TRI_B) |=> !pin.drive_en)
        else $error("output driven during short with tristate response");

    a_short_rail_high: assert property (
        !DIGITAL_VARIANT && short_act && setup_r[B_LOCK] && short_mode == SHORT_RAIL
        |=> pin.drive_en && pin.force_high)
        else $error("output not at rail on short");

    a_short_needs_arm: assert property (
        (state_r != ST_LOAD) && !armed_r |=> ##[0:2] !status_w[ST_SHORT] && $stable(armed_r))
        else $error("short reported while not armed");

    a_startup_code: assert property (
        state_r == ST_WAIT_SAMPLE && !setup_r[B_SENT_ZERO]
        |=> sent.fc1 == SENT_START_CODE && !sent.status_err)
        else $error("wrong start-up value");

    a_ovv_ground: assert property (
        DIGITAL_VARIANT && ovv_raw && !setup_r[B_OVV_DIS] && setup_r[B_ERR_BAND] && !short_act
        |=> pin.force_low)
        else $error("overvoltage did not force ground");

    a_ovv_disabled: assert property (
        state_r == ST_RUNNING && setup_r[B_OVV_DIS] && !setup_r[B_ERR_BAND] |=> sent.fc1 != SENT_OVV_CODE
        || $past(pos_val) == SENT_OVV_CODE)
        else $error("overvoltage code sent with detection disabled");

    a_diag_hidden: assert property (
        setup_r[B_DIAG_HIDE] && state_r == ST_RUNNING |=> !sent.status_err)
        else $error("error bits shown while hidden");

    a_interp_follow: assert property (
        setup_r[B_INTERP] |=> ctl.interp_en && ctl.interp_steps == INTERP_STEPS)
        else $error("interpolator not enabled");

    a_fc2_select: assert property (
        state_r == ST_RUNNING && setup_r[B_FC2_MAG] |=> sent.fc2 == $past(mag_val))
        else $error("fast channel 2 content wrong");

    a_diag_sticky: assert property (
        setup_r[B_DIAG_LATCH] && $stable(setup_r) && |diag_q |=> |diag_q)
        else $error("latched diagnosis cleared");

    a_wb_ack_answer: assert property (req && !ack_r |=> ack_r)
        else $error("request not acknowledged in the next cycle");

    a_load_word: assert property (
        rst_b && state_r == ST_LOAD |=> setup_r == $past(nvm_word) && armed_r == setup_r[B_LOCK])
        else $error("stored word not loaded after reset");

    a_proto_select: assert property (
        DIGITAL_VARIANT && setup_r[B_PROTO_SENT] |=> ctl.proto_sent)
        else $error("output protocol not selected");

    a_short_rail_low: assert property (
        !DIGITAL_VARIANT && short_act && setup_r[B_LOCK] && short_mode == SHORT_GND
        |=> pin.drive_en && pin.force_low)
        else $error("output not at ground on short");

    a_short_digital_tri: assert property (
        DIGITAL_VARIANT && short_act |=> !pin.drive_en)
        else $error("digital output driven during short");

    a_err_band_high: assert property (
        !DIGITAL_VARIANT && err_act && !short_act && !setup_r[B_ERR_BAND] |=> pin.force_high && !pin.force_low)
        else $error("error not signalled at the rail");

    a_err_band_low: assert property (
        !DIGITAL_VARIANT && err_act && !short_act && setup_r[B_ERR_BAND] |=> pin.force_low && !pin.force_high)
        else $error("error not signalled at ground");

    a_ovv_code: assert property (
        state_r == ST_RUNNING && ovv_act && !setup_r[B_ERR_BAND] |=> sent.fc1 == SENT_OVV_CODE)
        else $error("overvoltage code not sent");

    a_ovv_pwm: assert property (
        DIGITAL_VARIANT && ovv_act && !short_act && !setup_r[B_ERR_BAND] && !setup_r[B_PROTO_SENT]
        |=> pin.pwm_half_freq && pin.pwm_duty75)
        else $error("overvoltage PWM pattern missing");

    a_start_zero: assert property (
        state_r == ST_WAIT_SAMPLE && setup_r[B_SENT_ZERO]
        |=> sent.fc1 == SENT_ZERO_CODE && sent.fc2 == SENT_ZERO_CODE)
        else $error("start-up samples not zero");

    a_start_end: assert property (
        state_r == ST_WAIT_SAMPLE && sample_valid |=> state_r == ST_RUNNING)
        else $error("start-up did not end on the first sample");

    a_diag_live: assert property (
        rst_b && !setup_r[B_DIAG_LATCH] |=> diag_q == $past(diag_raw))
        else $error("diagnosis flags do not follow conditions");

    a_diag_keep: assert property (
        rst_b && setup_r[B_DIAG_LATCH] |=> (diag_q & $past(diag_q)) == $past(diag_q))
        else $error("latched diagnosis bit lost");

    a_diag_show: assert property (
        state_r == ST_RUNNING && !setup_r[B_DIAG_HIDE] && |diag_q |=> sent.status_err)
        else $error("diagnostic error not shown");

    c_wb_write: cover property (wr_hit && !setup_r[B_LOCK]);
    c_short_event: cover property (short_act ##1 !pin.drive_en);
    c_ovv_event: cover property (ovv_act ##1 sent.fc1 == SENT_OVV_CODE);
    c_start_run: cover property (state_r == ST_WAIT_SAMPLE ##1 state_r == ST_RUNNING);
    c_short_rail: cover property (short_act && short_mode == SHORT_RAIL ##1 pin.force_high);

endmodule : ssd_setup_decode

//--- shared/ssd_pkg.sv
// Constants, field layout and carrier types for the setup word decoder.
// Assumes one 125 MHz clock, an active-low asynchronous reset and a classic Wishbone master.
//
// Functional notes
// - The setup word is a 16-bit register selecting diagnosis, mode and lock.
// - Bit 15 enables the output interpolator, 32 sub-steps per output step.
// - Bit 13 picks fast channel 2 content: temperature or field amplitude.
// - On digital variants bit 12 picks PWM at 0 or SENT at 1.
// - Short field 0 or 3 tristates the output on a detected short.
// - With lock and analog output, field 1 drives rail, 2 drives ground.
// - On analog variants bit 7 puts the error band at rail or ground.
// - On digital variants bit 7 picks error code or ground on overvoltage.
// - Bit 4 picks SENT start-up value: 4094 without error bits, or zeros.
// - Bit 3 at 1 disables overvoltage detection.
// - Bit 2 makes diagnosis bits sticky until the next power-on reset or until bit 2 is cleared.
// - Bit 1 at 1 hides diagnostic errors from the output.
// - Bit 0 locks the configuration against further changes.
// - Short response exists for two sensors sharing one module.
// - Short detection works only after lock and a following power-on reset.
package ssd_pkg;

    localparam int SETUP_W = 16;
    localparam int SAMPLE_W = 12;
    localparam int ADR_W = 8;

    // Setup word field positions.
    localparam int B_INTERP = 15;
    localparam int B_FC2_MAG = 13;
    localparam int B_PROTO_SENT = 12;
    localparam int B_SHORT_LO = 8;
    localparam int B_ERR_BAND = 7;
    localparam int B_BURN_IN = 6;
    localparam int B_FUNC_NORMAL = 5;
    localparam int B_SENT_ZERO = 4;
    localparam int B_OVV_DIS = 3;
    localparam int B_DIAG_LATCH = 2;
    localparam int B_DIAG_HIDE = 1;
    localparam int B_LOCK = 0;

    // Short response field codes.
    localparam logic [1:0] SHORT_TRI_A = 2'h0;
    localparam logic [1:0] SHORT_RAIL = 2'h1;
    localparam logic [1:0] SHORT_GND = 2'h2;
    localparam logic [1:0] SHORT_TRI_B = 2'h3;

    localparam logic [5:0] INTERP_STEPS = 6'h20;
    localparam logic [5:0] INTERP_OFF = 6'h01;

    // SENT data codes.
    localparam logic [SAMPLE_W-1:0] SENT_OVV_CODE = 12'hFFB;
    localparam logic [SAMPLE_W-1:0] SENT_START_CODE = 12'hFFE;
    localparam logic [SAMPLE_W-1:0] SENT_ZERO_CODE = 12'h000;

    // Register byte offsets and status layout.
    localparam logic [ADR_W-1:0] ADDR_SETUP1 = 8'h00;
    localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h04;
    localparam int ST_DIAG_LO = 0;
    localparam int ST_OVV = 8;
    localparam int ST_SHORT = 9;
    localparam int ST_ARMED = 10;
    localparam int ST_LOCKED = 11;
    localparam int ST_RUN = 12;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADR_W-1:0] adr;
        logic [31:0] dat;
    } ssd_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ssd_wb_rsp_t;

    typedef struct packed {
        logic interp_en;
        logic [5:0] interp_steps;
        logic fc2_mag;
        logic proto_sent;
        logic burn_in;
        logic func_normal;
        logic ovv_det_en;
        logic diag_latch;
        logic diag_show;
    } ssd_ctl_t;

    typedef struct packed {
        logic drive_en;
        logic force_high;
        logic force_low;
        logic pwm_half_freq;
        logic pwm_duty75;
    } ssd_pin_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] fc1;
        logic [SAMPLE_W-1:0] fc2;
        logic status_err;
    } ssd_sent_t;

    typedef enum logic [1:0] {
        ST_LOAD,
        ST_WAIT_SAMPLE,
        ST_RUNNING
    } ssd_start_t;

endpackage : ssd_pkg

//--- hw/ssd_diag_latch.sv
// Diagnosis flag holder: follows live conditions or keeps them sticky.
// Assumes rst_b is the power-on reset; it or a low latch_en clears sticky flags.
module ssd_diag_latch #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic latch_en,
    input wire logic [W-1:0] cond,
    output logic [W-1:0] flags
);
    import ssd_pkg::*;

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // A raised condition always wins, so a set is never lost while latched.
    always_comb begin
        flags_nxt = latch_en ? (flags_r | cond) : cond;
    end

    // Reset clears a sticky flag, and so does dropping latch_en, after which flags follow cond.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;

endmodule : ssd_diag_latch

//--- dv/ssd_ctrl_model.sv
// Model of the controller that reads the sensor output pin.
// Assumes the line has no pull resistor, so a released pin never shows a steady level.
module ssd_ctrl_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input ssd_pkg::ssd_pin_t pin,
    input wire logic nominal,
    output logic level
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssd_pkg::*;
    logic last_r;
    // A forced level wins over the signal; a released pin flips every cycle,
    // so that the simulator cannot settle it to a convenient value.
    always_comb begin
        if (pin.drive_en !== 1'b1) begin
            level = ~last_r;
        end else if (pin.force_low) begin
            level = 1'b0;
        end else if (pin.force_high) begin
            level = 1'b1;
        end else begin
            level = nominal;
        end
    end
    // Remember what the controller saw last.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_r <= 1'b0;
        end else begin
            last_r <= level;
        end
    end
endmodule : ssd_ctrl_model

//--- dv/sensor_setup_config_decode_tb.sv
// Self-checking bench for the setup word decoder, digital and analog builds side by side.
// Assumes the decoder acks one cycle after a request and loads nvm_word just after reset.
module sensor_setup_config_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    ssd_wb_req_t wb_req = '0;
    ssd_wb_rsp_t wb_rsp;
    ssd_wb_rsp_t a_rsp;
    logic [15:0] nvm_word = '0;
    logic [7:0] diag_raw = '0;
    logic ovv_raw = 1'b0;
    logic short_raw = 1'b0;
    logic sample_valid = 1'b0;
    logic nominal = 1'b0;
    logic [11:0] pos_val = '0;
    logic [11:0] temp_val = '0;
    logic [11:0] mag_val = '0;
    ssd_ctl_t ctl;
    ssd_pin_t pin;
    ssd_pin_t a_pin;
    ssd_sent_t sent;
    logic [7:0] diag_flags;
    logic [7:0] v;
    logic level;
    logic [63:0] exp_q[$];
    logic [63:0] ex;
    logic [15:0] w;
    logic [1:0] f;
    logic [2:0] m3;
    int n_fail = 0;
    int compares = 0;
    int cyc_n = 0;
    integer seed = 32'hdda9420c;

    // Both builds share every input; the analog one is judged on its pin only.
    ssd_setup_decode #(.DIGITAL_VARIANT(1'b1), .DIAG_W(8)) ssd_setup_decode_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .nvm_word(nvm_word),
        .diag_raw(diag_raw), .ovv_raw(ovv_raw), .short_raw(short_raw), .sample_valid(sample_valid),
        .pos_val(pos_val), .temp_val(temp_val), .mag_val(mag_val), .ctl(ctl), .pin(pin),
        .sent(sent), .diag_flags(diag_flags));
    ssd_setup_decode #(.DIGITAL_VARIANT(1'b0), .DIAG_W(8)) ssd_setup_decode_an_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(a_rsp), .nvm_word(nvm_word),
        .diag_raw(diag_raw), .ovv_raw(ovv_raw), .short_raw(short_raw), .sample_valid(sample_valid),
        .pos_val(pos_val), .temp_val(temp_val), .mag_val(mag_val), .ctl(), .pin(a_pin),
        .sent(), .diag_flags());
    ssd_ctrl_model ssd_ctrl_model_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .pin(pin), .nominal(nominal), .level(level));

    // Free-running 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    task automatic final_report();
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // One classic cycle; the request is held until ack is seen at a rising edge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        wb_req <= {1'b1, 1'b1, we, s, a, 16'h0000, d};
        do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
        wb_req <= '0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        wb(1'b1, a, d, s);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
        exp_q.push_back({msk, e});
        wb(1'b0, a, 16'h0000, 4'hF);
    endtask : rd

    // Holds reset for five cycles; the stored word is loaded at the first edge after release.
    task automatic rst(input logic [15:0] word);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        nvm_word <= word;
        sample_valid <= 1'b0;
        short_raw <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : rst

    function automatic logic [13:0] ctl_exp(input logic [15:0] x);
        return {x[B_INTERP], x[B_INTERP] ? INTERP_STEPS : INTERP_OFF, x[B_FC2_MAG], x[B_PROTO_SENT],
                x[B_BURN_IN], x[B_FUNC_NORMAL], ~x[B_OVV_DIS], x[B_DIAG_LATCH], ~x[B_DIAG_HIDE]};
    endfunction : ctl_exp

    // Read data is judged at the acking edge against the oldest pending note; masks skip live bits.
    always @(posedge ref_clk) begin
        if (wb_rsp.ack === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0) begin
            ex = exp_q.pop_front();
            chk(wb_rsp.dat & ex[63:32], ex[31:0] & ex[63:32]);
        end
    end

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge ref_clk) begin
        cyc_n++;
        nominal <= 1'($random(seed));
        if (cyc_n == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        pos_val = 12'($random(seed));
        temp_val = 12'($random(seed));
        mag_val = 12'($random(seed));
        rst(16'h0000);
        rd(ADDR_STATUS, 32'h0, 32'h1C00);
        // Random words with reserved and lock bits clear, then the reserved bits alone.
        for (int i = 0; i < 9; i++) begin
            w = (i == 8) ? 16'h4C00 : 16'($random(seed)) & 16'hB3FE;
            wr(ADDR_SETUP1, w, 4'h3);
            rd(ADDR_SETUP1, {16'h0, w}, '1);
            tick(2);
            chk(ctl, ctl_exp(w));
        end
        wr(ADDR_SETUP1, 16'h0000, 4'h3);
        wr(ADDR_SETUP1, 16'hFFFE, 4'h1);
        wr(ADDR_STATUS, 16'hFFFF, 4'h3);
        rd(ADDR_SETUP1, 32'h00FE, '1);
        rd(8'h10, 32'h0, '1);
        rst(16'h1000);
        chk({sent.fc1, sent.status_err}, {SENT_START_CODE, 1'b0});
        rd(ADDR_STATUS, 32'h0, 32'h1000);
        sample_valid <= 1'b1;
        tick(4);
        chk({sent.fc1, sent.fc2}, {pos_val, temp_val});
        rd(ADDR_STATUS, 32'h1000, 32'h1000);
        wr(ADDR_SETUP1, 16'h3000, 4'h3);
        tick(2);
        chk(sent.fc2, mag_val);
        ovv_raw <= 1'b1;
        tick(2);
        chk(sent.fc1, SENT_OVV_CODE);
        rd(ADDR_STATUS, 32'h100, 32'h100);
        wr(ADDR_SETUP1, 16'h3008, 4'h3);
        tick(2);
        chk(sent.fc1, pos_val);
        wr(ADDR_SETUP1, 16'h2000, 4'h3);
        tick(2);
        chk({pin.pwm_half_freq, pin.pwm_duty75}, 2'b11);
        wr(ADDR_SETUP1, 16'h2080, 4'h3);
        tick(2);
        chk({pin.force_low, level}, 2'b10);
        ovv_raw <= 1'b0;
        rst(16'h1010);
        chk({sent.fc1, sent.fc2}, 24'h0);
        sample_valid <= 1'b1;
        // Diagnosis flags: sticky, then live, with the analog error band following them.
        v = 8'($random(seed)) | 8'h01;
        wr(ADDR_SETUP1, 16'h0004, 4'h3);
        diag_raw <= v;
        // The error band sits behind the flag register and the pin register, two edges deep.
        tick(3);
        chk(a_pin.force_high, 1'b1);
        diag_raw <= '0;
        tick(2);
        chk(diag_flags, v);
        rd(ADDR_STATUS, {24'h0, v}, 32'hFF);
        wr(ADDR_SETUP1, 16'h0080, 4'h3);
        tick(2);
        chk(diag_flags, 8'h00);
        diag_raw <= v;
        tick(3);
        chk({diag_flags, a_pin.force_low}, {v, 1'b1});
        wr(ADDR_SETUP1, 16'h0082, 4'h3);
        tick(2);
        chk(a_pin.force_low, 1'b0);
        diag_raw <= '0;
        // Every short response code with lock stored before reset.
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            rst({6'h0, f, 8'h01});
            sample_valid <= 1'b1;
            short_raw <= 1'b1;
            tick(2);
            m3 = (f == SHORT_RAIL || f == SHORT_GND) ? 3'b111 : 3'b100;
            chk({pin.drive_en, {a_pin.drive_en, a_pin.force_high, a_pin.force_low} & m3},
                {1'b0, (f == SHORT_RAIL) ? 3'b110 : (f == SHORT_GND) ? 3'b101 : 3'b000});
        end
        wr(ADDR_SETUP1, 16'h0000, 4'h3);
        rd(ADDR_SETUP1, 32'h0301, '1);
        rd(ADDR_STATUS, 32'hC00, 32'hC00);
        rst(16'h0000);
        sample_valid <= 1'b1;
        wr(ADDR_SETUP1, 16'h0001, 4'h3);
        short_raw <= 1'b1;
        tick(2);
        chk(pin.drive_en, 1'b1);
        rd(ADDR_STATUS, 32'h800, 32'hC00);
        final_report();
    end
endmodule : sensor_setup_config_decode_tb
